// ### dv/refao_dsp_model.sv
// downstream audio processor model on the serial audio link
`timescale 1ns/1ps
module refao_dsp_model (
  // link pins
  input wire logic bitClock,
  input wire logic serialAudioOut,
  input wire logic frameClockOut,
  output logic auxAudioIn,
  output logic frameClockIn,
  // last left word seen
  output logic [23:0] leftWord
);
  logic prevFrame;
  logic [23:0] shiftReg;
  logic [5:0] bitCount;
  logic [5:0] slotCount;
  initial begin
    prevFrame = 1'b0;
    shiftReg = 24'h00_0000;
    bitCount = 6'h3F;
    slotCount = 6'h00;
    leftWord = 24'hFF_FFFF;
    auxAudioIn = 1'b0;
    frameClockIn = 1'b0;
  end
  // msb first on rising edge, word starts at frame clock rise
  always @(posedge bitClock) begin
    prevFrame <= frameClockOut;
    if (frameClockOut && !prevFrame) begin
      shiftReg <= {23'h00_0000, serialAudioOut};
      bitCount <= 6'h01;
    end else if (bitCount < 6'h18) begin
      shiftReg <= {shiftReg[22:0], serialAudioOut};
      bitCount <= bitCount + 6'h01;
      if (bitCount == 6'h17) leftWord <= {shiftReg[22:0], serialAudioOut};
    end
  end
  // own outputs move on falling edge; aux toggles so a stale bit never looks held
  always @(negedge bitClock) begin
    auxAudioIn <= ~auxAudioIn;
    slotCount <= slotCount + 6'h01;
    frameClockIn <= ~slotCount[5];
  end
endmodule

// ### dv/testbench.sv
// self-checking bench for the receiver error flags and serial audio output block
`timescale 1ns/1ps
module testbench;
  import refao_pkg::*;
  logic ref_clk, reset_n, bitClock, subframeStb, blockStb, nonaudioBit;
  logic nonlinearStreamDetect, compressedCdDetect, preemphasisFlag, qSyncStb, tapeCategory;
  logic startIdSeen, frameTick, registerMode, pllOff, tapeStartHoldoff, statusRead;
  logic formatChangeFlag, bufferInit, errorIrqPin, streamIrqPin, validityPin;
  logic frameClockIn, auxAudioIn, serialAudioOut, frameClockOut, frameClockOe;
  logic [39:0] chanStatus;
  logic [79:0] qSubcode;
  logic [3:0] sampleRateCode;
  logic [1:0] clockOpMode, errorHoldSelect;
  logic [8:0] errorMask, streamMask;
  logic [2:0] fmtSel;
  logic [23:0] leftWord;
  refao_subframe_t subframe;
  refao_live_t liveStatus;
  refao_latch_t latchedStatus;
  int miscompares = 0;
  int tests_run = 0;

  refao_top refao_top_inst (.ref_clk(ref_clk), .reset_n(reset_n), .subframeStb(subframeStb),
    .subframe(subframe), .blockStb(blockStb), .chanStatus(chanStatus), .nonaudioBit(nonaudioBit),
    .nonlinearStreamDetect(nonlinearStreamDetect), .compressedCdDetect(compressedCdDetect),
    .sampleRateCode(sampleRateCode), .preemphasisFlag(preemphasisFlag), .qSyncStb(qSyncStb),
    .qSubcode(qSubcode), .tapeCategory(tapeCategory), .startIdSeen(startIdSeen), .frameTick(frameTick),
    .registerMode(registerMode), .pllOff(pllOff), .clockOpMode(clockOpMode),
    .tapeStartHoldoff(tapeStartHoldoff), .errorHoldSelect(errorHoldSelect), .errorMask(errorMask),
    .streamMask(streamMask), .statusRead(statusRead), .liveStatus(liveStatus),
    .latchedStatus(latchedStatus), .formatChangeFlag(formatChangeFlag), .bufferInit(bufferInit),
    .errorIrqPin(errorIrqPin), .streamIrqPin(streamIrqPin), .validityPin(validityPin),
    .bitClock(bitClock), .frameClockIn(frameClockIn), .formatSelectMsb(fmtSel[2]),
    .formatSelectMid(fmtSel[1]), .formatSelectLsb(fmtSel[0]), .auxAudioIn(auxAudioIn),
    .serialAudioOut(serialAudioOut), .frameClockOut(frameClockOut), .frameClockOe(frameClockOe));

  refao_dsp_model refao_dsp_model_inst (.bitClock(bitClock), .serialAudioOut(serialAudioOut),
    .frameClockOut(frameClockOut), .auxAudioIn(auxAudioIn), .frameClockIn(frameClockIn),
    .leftWord(leftWord));

  // receive clock and unrelated link clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    bitClock = 1'b0;
    #37;
    forever #80 bitClock = ~bitClock;
  end

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // one sub-frame; flags are settled two edges later
  task automatic send(input logic [23:0] d, input logic r, input logic v, input logic perr, input logic bad);
    subframe = '{data: d, right: r, parityErr: perr, biphaseErr: 1'b0, validity: v,
      preambleErr: 1'b0, spacingErr: bad};
    subframeStb = 1'b1;
    cyc(1);
    subframeStb = 1'b0;
    cyc(2);
  endtask
  task automatic relock;
    for (int i = 0; i < 4; i++) send(24'h00_0000, i[0], 1'b1, 1'b0, 1'b0);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      frameTick = 1'b1;
      cyc(1);
      frameTick = 1'b0;
      cyc(1);
    end
  endtask
  task automatic rd;
    statusRead = 1'b1;
    cyc(1);
    statusRead = 1'b0;
    cyc(2);
  endtask
  task automatic qsync(input logic [79:0] v);
    qSubcode = v;
    qSyncStb = 1'b1;
    cyc(1);
    qSyncStb = 1'b0;
    cyc(2);
  endtask
  task automatic blk(input logic [39:0] cs, input logic na);
    chanStatus = cs;
    nonaudioBit = na;
    blockStb = 1'b1;
    cyc(1);
    blockStb = 1'b0;
    cyc(2);
  endtask
  task automatic tape;
    startIdSeen = 1'b1;
    cyc(1);
    startIdSeen = 1'b0;
    cyc(2);
  endtask

  // a hang is cut short here
  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    wrap_up();
  end

  initial begin
    {reset_n, subframeStb, blockStb, nonaudioBit, nonlinearStreamDetect, compressedCdDetect} = 6'h00;
    {preemphasisFlag, qSyncStb, tapeCategory, startIdSeen, frameTick, registerMode} = 6'h00;
    {pllOff, tapeStartHoldoff, statusRead} = 3'h0;
    subframe = '0;
    chanStatus = 40'h00_0000_0000;
    qSubcode = '0;
    sampleRateCode = 4'h0;
    clockOpMode = 2'h0;
    errorHoldSelect = 2'h1;
    errorMask = 9'h000;
    streamMask = 9'h000;
    fmtSel = FMT_LJ24;
    cyc(8);
    reset_n = 1'b1;
    cyc(3);
    // unlocked after reset: zero data, validity low
    check("lockLost", liveStatus.lockLost, 1);
    check("bufferInit", bufferInit, 1);
    check("errorIrqPin", errorIrqPin, 1);
    check("validityPin", validityPin, 0);
    cyc(400);
    check("leftWord", leftWord, 0);
    relock();
    check("lockLost", liveStatus.lockLost, 0);
    check("usable", liveStatus.usable, 1);
    send(24'h00_0000, 1'b0, 1'b0, 1'b0, 1'b0);
    check("usable", liveStatus.usable, 0);
    send(24'h00_0000, 1'b1, 1'b1, 1'b0, 1'b1);
    check("lockLost", liveStatus.lockLost, 1);
    relock();
    // left-justified word, then a parity fault repeats it; let any pending pair go first
    cyc(250);
    send(24'h5A_C3E1, 1'b0, 1'b1, 1'b0, 1'b0);
    send(24'h5A_C3E1, 1'b1, 1'b1, 1'b0, 1'b0);
    cyc(500);
    check("leftWord", leftWord, 24'h5A_C3E1);
    send(24'h24_6801, 1'b0, 1'b1, 1'b1, 1'b0);
    check("frameCheck", liveStatus.frameCheck, 1);
    check("errorIrqPin", errorIrqPin, 1);
    send(24'h5A_C3E1, 1'b1, 1'b1, 1'b0, 1'b0);
    cyc(500);
    check("leftWord", leftWord, 24'h5A_C3E1);
    send(24'h00_0000, 1'b0, 1'b1, 1'b0, 1'b0);
    check("frameCheck", liveStatus.frameCheck, 0);
    send(24'h00_0000, 1'b1, 1'b1, 1'b0, 1'b0);
    ticks(1020);
    check("errorIrqPin", errorIrqPin, 1);
    ticks(4);
    cyc(2);
    check("errorIrqPin", errorIrqPin, 0);
    // every detector combination
    for (int i = 0; i < 4; i++) begin
      {nonlinearStreamDetect, compressedCdDetect} = i[1:0];
      cyc(3);
      check("compressed", liveStatus.compressed, |i[1:0]);
      check("streamIrqPin", streamIrqPin, |i[1:0]);
    end
    {nonlinearStreamDetect, compressedCdDetect} = 2'h0;
    blk(40'h00_0000_0000, 1'b1);
    check("nonaudio", liveStatus.nonaudio, 1);
    check("streamIrqPin", streamIrqPin, 1);
    blk(40'h00_0000_0000, 1'b0);
    check("nonaudio", liveStatus.nonaudio, 0);
    rd();
    blk(40'h12_3456_789A, 1'b0);
    check("csChanged", latchedStatus.chanStatus, 1);
    rd();
    check("csChanged", latchedStatus.chanStatus, 0);
    blk(40'h12_3456_789A, 1'b0);
    check("csChanged", latchedStatus.chanStatus, 0);
    qsync(80'h1);
    rd();
    qsync(80'h1);
    check("subcode", latchedStatus.subcode, 0);
    qsync(80'h2);
    check("subcode", latchedStatus.subcode, 1);
    cyc(5);
    check("subcode", latchedStatus.subcode, 1);
    rd();
    check("subcode", latchedStatus.subcode, 0);
    // rate change, then emphasis change, each one sub-frame long
    for (int i = 0; i < 2; i++) begin
      if (i == 0) sampleRateCode = 4'h3;
      else preemphasisFlag = 1'b1;
      send(24'h00_0000, 1'b0, 1'b1, 1'b0, 1'b0);
      check("formatChange", formatChangeFlag, 1);
      send(24'h00_0000, 1'b1, 1'b1, 1'b0, 1'b0);
      check("formatChange", formatChangeFlag, 0);
    end
    tapeCategory = 1'b1;
    tapeStartHoldoff = 1'b1;
    tape();
    check("tapeStart", latchedStatus.tapeStart, 1);
    rd();
    tape();
    check("tapeStart", latchedStatus.tapeStart, 0);
    ticks(3841);
    tape();
    check("tapeStart", latchedStatus.tapeStart, 1);
    rd();
    tapeStartHoldoff = 1'b0;
    tape();
    check("tapeStart", latchedStatus.tapeStart, 1);
    // masked event pins, shortest error hold
    registerMode = 1'b1;
    errorHoldSelect = 2'h0;
    errorMask = ~(9'h001 << EV_CHECK);
    streamMask = ~(9'h001 << EV_CMP);
    send(24'h00_0000, 1'b0, 1'b1, 1'b1, 1'b0);
    check("errorIrqPin", errorIrqPin, 1);
    send(24'h00_0000, 1'b1, 1'b1, 1'b0, 1'b0);
    ticks(508);
    check("errorIrqPin", errorIrqPin, 1);
    ticks(4);
    cyc(2);
    check("errorIrqPin", errorIrqPin, 0);
    nonlinearStreamDetect = 1'b1;
    cyc(3);
    check("streamIrqPin", streamIrqPin, 1);
    nonlinearStreamDetect = 1'b0;
    cyc(2);
    check("streamIrqPin", streamIrqPin, 0);
    streamMask = 9'h1FF;
    nonlinearStreamDetect = 1'b1;
    cyc(3);
    check("streamIrqPin", streamIrqPin, 0);
    check("compressed", liveStatus.compressed, 1);
    send(24'h00_0000, 1'b0, 1'b1, 1'b0, 1'b1);
    check("errorIrqPin", errorIrqPin, 1);
    pllOff = 1'b1;
    clockOpMode = COM_PLL_OFF;
    cyc(3);
    check("errorIrqPin", errorIrqPin, 0);
    check("streamIrqPin", streamIrqPin, 0);
    // clock mode 1 routes the toggling aux input to the output
    send(24'h12_3456, 1'b1, 1'b1, 1'b0, 1'b0);
    cyc(300);
    check("auxWord", leftWord == 24'hAA_AAAA || leftWord == 24'h55_5555, 1);
    // master modes drive the frame clock, slave modes do not
    for (int i = 0; i < 8; i++) begin
      fmtSel = i[2:0];
      cyc(10);
      check("frameClockOe", frameClockOe, i < 6);
    end
    wrap_up();
  end
endmodule

// ### src/refao_pkg.sv
// constants and carrier types for the receiver error flags and serial audio output block
package refao_pkg;
  // audio word and slot geometry
  localparam int AW = 24;
  localparam logic [4:0] SLOT_LAST = 5'h1F;
  localparam logic [5:0] FRAME_LAST = 6'h3F;
  localparam logic [5:0] WORD_LEN = 6'h18;
  localparam logic [5:0] WORD_MSB = 6'h17;
  localparam logic [5:0] RJ16_LEN = 6'h10;
  localparam logic [5:0] RJ18_LEN = 6'h12;
  localparam logic [5:0] RJ20_LEN = 6'h14;
  localparam logic [5:0] SLOT_LEN = 6'h20;
  localparam logic [5:0] I2S_DELAY = 6'h01;
  localparam logic [4:0] SLAVE_LAT = 5'h02;
  localparam logic [5:0] POS_STEP = 6'h01;
  // format select codes
  localparam logic [2:0] FMT_RJ16 = 3'h0;
  localparam logic [2:0] FMT_RJ18 = 3'h1;
  localparam logic [2:0] FMT_RJ20 = 3'h2;
  localparam logic [2:0] FMT_RJ24 = 3'h3;
  localparam logic [2:0] FMT_LJ24 = 3'h4;
  localparam logic [2:0] FMT_I2S = 3'h5;
  localparam logic [2:0] FMT_SLV_LJ = 3'h6;
  localparam logic [2:0] FMT_SLV_I2S = 3'h7;
  // clock operation modes
  localparam logic [1:0] COM_PLL_OFF = 2'h1;
  localparam logic [1:0] COM_AUTO = 2'h2;
  localparam logic [1:0] COM_AUX = 2'h3;
  // event vector positions
  localparam int NEV = 9;
  localparam int EV_LOCK = 0;
  localparam int EV_CHECK = 1;
  localparam int EV_CMP = 2;
  localparam int EV_VALID = 3;
  localparam int EV_NAUD = 4;
  localparam int EV_FMT = 5;
  localparam int EV_SUB = 6;
  localparam int EV_CS = 7;
  localparam int EV_TAPE = 8;
  // timing in frame-clock periods
  localparam logic [11:0] TAPE_HOLDOFF = 12'hF00;
  localparam logic [12:0] HOLD_512 = 13'h0200;
  localparam logic [12:0] HOLD_1024 = 13'h0400;
  localparam logic [12:0] HOLD_2048 = 13'h0800;
  localparam logic [12:0] HOLD_4096 = 13'h1000;
  localparam logic [12:0] HOLD_ONE = 13'h0001;
  // carriers
  typedef struct packed {
    logic [AW-1:0] data;
    logic right;
    logic parityErr;
    logic biphaseErr;
    logic validity;
    logic preambleErr;
    logic spacingErr;
  } refao_subframe_t;
  typedef struct packed {
    logic lockLost;
    logic frameCheck;
    logic compressed;
    logic usable;
    logic nonaudio;
  } refao_live_t;
  typedef struct packed {
    logic subcode;
    logic chanStatus;
    logic tapeStart;
  } refao_latch_t;
  typedef struct packed {
    logic [AW-1:0] left;
    logic [AW-1:0] right;
    logic mute;
    logic useAux;
  } refao_xfer_t;
  typedef enum {RF_LOCKED, RF_UNLOCKED} refao_lock_t;
endpackage

// ### src/refao_top.sv
// receiver error flags, interrupt pins and serial audio output formatter
//
// Behaviour
// - lock lost set on wrong preamble spacing or invalid preamble
// - frame-check error from parity or biphase fault, per sub-frame
// - compressed flag is OR of the two stream detectors
// - usable flag follows received validity bit each sub-frame
// - non-audio flag mirrors channel-status bit once per block
// - rate or emphasis change raises format-change for one sub-frame
// - subcode-changed set when new Q-subcode differs from previous
// - channel-status-changed set when block bits differ from previous
// - tape start with optional 3840-frame repeat holdoff
// - pin mode: error pin lock|check, stream pin compressed|non-audio
// - error pin held 1024 frames after its events clear
// - register mode: pins are masked ORs of nine events
// - selectable error hold; stream pin falls at once
// - five live status bits follow events without latching
// - three event bits latch until status read clears them
// - lock loss clears buffers; pins use pin-mode sources
// - frame-check error repeats last good sub-frame data
// - unlock outputs zero data in clock mode 0 and drives validity pin low
// - three-bit format select picks one of eight formats
// - data out on falling bit clock, aux in on rising; master modes
// - short formats truncate LSBs of the sub-frame
// - aux routed out in clock modes 1 and 3, mode 2 unlocked
// - PLL off in clock mode 1 holds both pins low
`timescale 1ns/1ps
module refao_top #(
  parameter int CSW = 40,
  parameter int QW = 80,
  parameter int RELOCK = 4
) (
  // receive clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // recovered stream
  input wire logic subframeStb,
  input wire refao_pkg::refao_subframe_t subframe,
  input wire logic blockStb,
  input wire logic [CSW-1:0] chanStatus,
  input wire logic nonaudioBit,
  input wire logic nonlinearStreamDetect,
  input wire logic compressedCdDetect,
  input wire logic [3:0] sampleRateCode,
  input wire logic preemphasisFlag,
  input wire logic qSyncStb,
  input wire logic [QW-1:0] qSubcode,
  input wire logic tapeCategory,
  input wire logic startIdSeen,
  input wire logic frameTick,
  // control
  input wire logic registerMode,
  input wire logic pllOff,
  input wire logic [1:0] clockOpMode,
  input wire logic tapeStartHoldoff,
  input wire logic [1:0] errorHoldSelect,
  input wire logic [refao_pkg::NEV-1:0] errorMask,
  input wire logic [refao_pkg::NEV-1:0] streamMask,
  input wire logic statusRead,
  // status and pins
  output refao_pkg::refao_live_t liveStatus,
  output refao_pkg::refao_latch_t latchedStatus,
  output logic formatChangeFlag,
  output logic bufferInit,
  output logic errorIrqPin,
  output logic streamIrqPin,
  output logic validityPin,
  // serial audio link
  input wire logic bitClock,
  input wire logic frameClockIn,
  input wire logic formatSelectMsb,
  input wire logic formatSelectMid,
  input wire logic formatSelectLsb,
  input wire logic auxAudioIn,
  output logic serialAudioOut,
  output logic frameClockOut,
  output logic frameClockOe
);
  import refao_pkg::*;

  refao_lock_t lockState_reg, lockState_next;
  logic [2:0] goodCnt_reg, goodCnt_next;
  refao_live_t live_reg, live_next;
  refao_latch_t latch_reg, latch_next;
  logic [4:0] fmtPrev_reg, fmtPrev_next;
  logic fmtChg_reg, fmtChg_next;
  logic [QW-1:0] qPrev_reg, qPrev_next;
  logic [CSW-1:0] csPrev_reg, csPrev_next;
  logic [11:0] tapeCnt_reg, tapeCnt_next;
  logic [12:0] holdCnt_reg, holdCnt_next;
  logic errPin_reg, errPin_next, strPin_reg, strPin_next, valPin_reg, valPin_next;
  logic [AW-1:0] good_reg [2];
  logic [AW-1:0] good_next [2];
  refao_xfer_t hold_reg, hold_next;
  logic req_reg, req_next, ackMeta_reg, ackSync_reg, ack_reg;
  logic [NEV-1:0] ev;
  logic unlocked, tapeHit, errSrc, strSrc, pllGate, pending;
  logic [12:0] holdLen;

  // ack from link domain, two flops
  always_ff @(posedge ref_clk) begin
    ackMeta_reg <= ack_reg;
    ackSync_reg <= ackMeta_reg;
  end

  // flag, interrupt and capture next state
  always_comb begin
    lockState_next = lockState_reg;
    goodCnt_next = goodCnt_reg;
    live_next = live_reg;
    fmtPrev_next = fmtPrev_reg;
    fmtChg_next = fmtChg_reg;
    qPrev_next = qPrev_reg;
    csPrev_next = csPrev_reg;
    tapeCnt_next = tapeCnt_reg;
    good_next = good_reg;
    hold_next = hold_reg;
    req_next = req_reg;
    if (subframeStb) begin
      if (subframe.preambleErr || subframe.spacingErr) begin
        lockState_next = RF_UNLOCKED;
        goodCnt_next = '0;
      end else if (lockState_reg == RF_UNLOCKED) begin
        goodCnt_next = goodCnt_reg + 3'h1;
        if (goodCnt_reg == 3'(RELOCK - 1)) begin
          lockState_next = RF_LOCKED;
        end
      end
      live_next.frameCheck = subframe.parityErr | subframe.biphaseErr;
      live_next.usable = subframe.validity;
      fmtChg_next = {sampleRateCode, preemphasisFlag} != fmtPrev_reg;
      fmtPrev_next = {sampleRateCode, preemphasisFlag};
    end
    unlocked = lockState_next == RF_UNLOCKED;
    live_next.lockLost = unlocked;
    live_next.compressed = nonlinearStreamDetect | compressedCdDetect;
    if (blockStb) begin
      live_next.nonaudio = nonaudioBit;
    end
    // held data only updates on clean sub-frames, so errors repeat it
    if (subframeStb && !unlocked && !live_next.frameCheck) begin
      good_next[subframe.right] = subframe.data;
    end
    tapeHit = tapeCategory && startIdSeen;
    latch_next = latch_reg & ~{3{statusRead}};
    if (qSyncStb) begin
      latch_next.subcode = latch_next.subcode | (qSubcode != qPrev_reg);
      qPrev_next = qSubcode;
    end
    if (blockStb) begin
      latch_next.chanStatus = latch_next.chanStatus | (chanStatus != csPrev_reg);
      csPrev_next = chanStatus;
    end
    if (tapeHit && (!tapeStartHoldoff || tapeCnt_reg == TAPE_HOLDOFF)) begin
      latch_next.tapeStart = 1'b1;
      tapeCnt_next = '0;
    end else if (frameTick && tapeCnt_reg != TAPE_HOLDOFF) begin
      tapeCnt_next = tapeCnt_reg + 12'h001;
    end
    // lock loss wipes the captured buffers
    if (unlocked) begin
      qPrev_next = '0;
      csPrev_next = '0;
      good_next[0] = '0;
      good_next[1] = '0;
    end
    // one stereo pair per handshake; hold is frozen while pending
    pending = req_reg != ackSync_reg;
    if (subframeStb && subframe.right && !pending) begin
      hold_next.left = good_next[0];
      hold_next.right = good_next[1];
      hold_next.mute = unlocked;
      hold_next.useAux = clockOpMode == COM_PLL_OFF || clockOpMode == COM_AUX
        || (clockOpMode == COM_AUTO && unlocked);
      req_next = ~req_reg;
    end
    ev = '0;
    ev[EV_LOCK] = live_next.lockLost;
    ev[EV_CHECK] = live_next.frameCheck;
    ev[EV_CMP] = live_next.compressed;
    ev[EV_VALID] = live_next.usable;
    ev[EV_NAUD] = live_next.nonaudio;
    ev[EV_FMT] = fmtChg_next;
    ev[EV_SUB] = latch_next.subcode;
    ev[EV_CS] = latch_next.chanStatus;
    ev[EV_TAPE] = latch_next.tapeStart;
    if (!registerMode || unlocked) begin
      errSrc = ev[EV_LOCK] | ev[EV_CHECK];
      strSrc = ev[EV_CMP] | ev[EV_NAUD];
    end else begin
      errSrc = |(ev & ~errorMask);
      strSrc = |(ev & ~streamMask);
    end
    case (registerMode ? errorHoldSelect : 2'h1)
      2'h0: holdLen = HOLD_512;
      2'h1: holdLen = HOLD_1024;
      2'h2: holdLen = HOLD_2048;
      default: holdLen = HOLD_4096;
    endcase
    pllGate = pllOff && clockOpMode == COM_PLL_OFF;
    holdCnt_next = holdCnt_reg;
    if (pllGate) begin
      holdCnt_next = '0;
    end else if (errSrc) begin
      holdCnt_next = holdLen;
    end else if (frameTick && holdCnt_reg != '0) begin
      holdCnt_next = holdCnt_reg - HOLD_ONE;
    end
    errPin_next = !pllGate && (errSrc || holdCnt_next != '0);
    strPin_next = !pllGate && strSrc;
    valPin_next = !unlocked && live_next.usable;
  end

  // flag and interrupt registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      lockState_reg <= RF_UNLOCKED;
      goodCnt_reg <= '0;
      live_reg <= '0;
      latch_reg <= '0;
      fmtPrev_reg <= '0;
      fmtChg_reg <= 1'b0;
      qPrev_reg <= '0;
      csPrev_reg <= '0;
      tapeCnt_reg <= TAPE_HOLDOFF;
      holdCnt_reg <= '0;
      errPin_reg <= 1'b0;
      strPin_reg <= 1'b0;
      valPin_reg <= 1'b0;
      good_reg[0] <= '0;
      good_reg[1] <= '0;
      hold_reg <= '0;
      req_reg <= 1'b0;
    end else begin
      lockState_reg <= lockState_next;
      goodCnt_reg <= goodCnt_next;
      live_reg <= live_next;
      latch_reg <= latch_next;
      fmtPrev_reg <= fmtPrev_next;
      fmtChg_reg <= fmtChg_next;
      qPrev_reg <= qPrev_next;
      csPrev_reg <= csPrev_next;
      tapeCnt_reg <= tapeCnt_next;
      holdCnt_reg <= holdCnt_next;
      errPin_reg <= errPin_next;
      strPin_reg <= strPin_next;
      valPin_reg <= valPin_next;
      good_reg <= good_next;
      hold_reg <= hold_next;
      req_reg <= req_next;
    end
  end

  assign liveStatus = live_reg;
  assign latchedStatus = latch_reg;
  assign formatChangeFlag = fmtChg_reg;
  assign bufferInit = live_reg.lockLost;
  assign errorIrqPin = errPin_reg;
  assign streamIrqPin = strPin_reg;
  assign validityPin = valPin_reg;

  // ---- link domain on the bit clock ----
  logic rstMeta, linkRst_n, reqMeta, reqSync, ack_next;
  logic [2:0] fmtMeta, fmtSync;
  logic frMeta, frSync, frLast;
  logic [5:0] pos_reg, pos_next, q;
  logic [31:0] auxSh_reg, auxSh_next;
  logic [AW-1:0] aux_reg [2];
  logic [AW-1:0] aux_next [2];
  refao_xfer_t frame_reg, frame_next;
  logic slave, i2s, sdo_next, fco_next, fcoe_next, sdo_reg, fco_reg, fcoe_reg, valid;
  logic [5:0] start, len, off;
  logic [AW-1:0] word;

  // reset, request, format and frame clock synchronisers
  always_ff @(posedge bitClock) begin
    rstMeta <= reset_n;
    linkRst_n <= rstMeta;
    reqMeta <= req_reg;
    reqSync <= reqMeta;
    fmtMeta <= {formatSelectMsb, formatSelectMid, formatSelectLsb};
    fmtSync <= fmtMeta;
    frMeta <= frameClockIn;
    frSync <= frMeta;
    frLast <= frSync;
  end

  // slot counter, aux capture on the rising edge, pair hand-over
  always_comb begin
    slave = fmtSync == FMT_SLV_LJ || fmtSync == FMT_SLV_I2S;
    i2s = fmtSync == FMT_I2S || fmtSync == FMT_SLV_I2S;
    pos_next = pos_reg + POS_STEP;
    if (slave && frSync != frLast) begin
      pos_next = {frSync == i2s, SLAVE_LAT};
    end
    auxSh_next = {auxSh_reg[30:0], auxAudioIn};
    aux_next = aux_reg;
    if (pos_reg[4:0] == SLOT_LAST) begin
      aux_next[pos_reg[5]] = i2s ? auxSh_next[30:7] : auxSh_next[31:8];
    end
    frame_next = frame_reg;
    ack_next = ack_reg;
    if ((pos_reg + POS_STEP) == FRAME_LAST && reqSync != ack_reg) begin // one bit early, msb of slot 0 is new
      frame_next = hold_reg;
      ack_next = reqSync;
    end
  end

  always_ff @(posedge bitClock) begin
    if (!linkRst_n) begin
      pos_reg <= '0;
      auxSh_reg <= '0;
      aux_reg[0] <= '0;
      aux_reg[1] <= '0;
      frame_reg <= '0;
      ack_reg <= 1'b0;
    end else begin
      pos_reg <= pos_next;
      auxSh_reg <= auxSh_next;
      aux_reg <= aux_next;
      frame_reg <= frame_next;
      ack_reg <= ack_next;
    end
  end

  // bit for the next slot; data leaves on the falling edge
  always_comb begin
    q = pos_reg + POS_STEP;
    start = '0;
    len = WORD_LEN;
    case (fmtSync)
      FMT_RJ16: len = RJ16_LEN;
      FMT_RJ18: len = RJ18_LEN;
      FMT_RJ20: len = RJ20_LEN;
      FMT_RJ24: len = WORD_LEN;
      FMT_I2S, FMT_SLV_I2S: start = I2S_DELAY;
      default: start = '0;
    endcase
    if (fmtSync <= FMT_RJ24) begin
      start = SLOT_LEN - len;
    end
    off = {1'b0, q[4:0]} - start;
    valid = {1'b0, q[4:0]} >= start && off < len;
    if (frame_reg.useAux) begin
      word = aux_reg[q[5]];
    end else if (frame_reg.mute) begin
      word = '0;
    end else begin
      word = q[5] ? frame_reg.right : frame_reg.left;
    end
    sdo_next = valid && word[5'(WORD_MSB - off)];
    fco_next = !slave && (q[5] == i2s);
    fcoe_next = !slave;
  end

  always_ff @(negedge bitClock) begin
    if (!linkRst_n) begin
      sdo_reg <= 1'b0;
      fco_reg <= 1'b0;
      fcoe_reg <= 1'b0;
    end else begin
      sdo_reg <= sdo_next;
      fco_reg <= fco_next;
      fcoe_reg <= fcoe_next;
    end
  end

  assign serialAudioOut = sdo_reg;
  assign frameClockOut = fco_reg;
  assign frameClockOe = fcoe_reg;

  // checks
  a_lock_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    subframeStb && (subframe.preambleErr || subframe.spacingErr) |=> liveStatus.lockLost && bufferInit)
    else $error("lock lost not raised on preamble fault");
  a_check_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
    subframeStb |=> liveStatus.frameCheck == $past(subframe.parityErr || subframe.biphaseErr))
    else $error("frame check flag wrong after sub-frame");
  a_fmt_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
    formatChangeFlag && subframeStb && $stable(sampleRateCode) && $stable(preemphasisFlag)
    && {sampleRateCode, preemphasisFlag} == $past({sampleRateCode, preemphasisFlag}) |=> !formatChangeFlag)
    else $error("format change flag longer than a sub-frame");
  a_latch_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    latchedStatus.subcode && !statusRead |=> latchedStatus.subcode)
    else $error("subcode changed flag dropped without a read");
  a_tape_gap: assert property (@(posedge ref_clk) disable iff (!reset_n)
    tapeStartHoldoff && !latchedStatus.tapeStart && tapeCnt_reg != TAPE_HOLDOFF |=> !latchedStatus.tapeStart)
    else $error("tape start set inside holdoff");
  a_err_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    errorIrqPin && !errSrc && !pllGate && !(frameTick && holdCnt_reg <= HOLD_ONE) |=> errorIrqPin)
    else $error("error pin fell before hold elapsed");
  a_stream_drop: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !strSrc ##1 !strSrc |-> !streamIrqPin)
    else $error("stream pin stayed high after events cleared");
  a_pll_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pllGate |=> !errorIrqPin && !streamIrqPin)
    else $error("interrupt pin high with pll off");
  a_valid_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
    liveStatus.lockLost |-> !validityPin)
    else $error("validity pin high while unlocked");
  a_mute_zero: assert property (@(negedge bitClock) disable iff (!linkRst_n)
    frame_reg.mute && !frame_reg.useAux |=> !serialAudioOut)
    else $error("nonzero data while muted");
endmodule
